// ### rtl/dwr_pkg.sv
/*
 * Shared constants, types and timing tables of the DRAM wait/ack and RAS timing block.
 * Assumes a single controller clock; all counts are in controller clock edges.
 */
package dwr_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] DWR_CFG_OFS       = 8'h00;
  localparam logic [7:0] DWR_STAT_OFS      = 8'h04;
  localparam logic [7:0] DWR_CFG_RST       = 8'h00;
  localparam int         DWR_ACK_STYLE_BIT = 7;
  localparam int         DWR_BW_LSB        = 4;
  localparam int         DWR_DLY_LSB       = 2;
  localparam int         DWR_RAS_LSB       = 0;

  // ----------------------------------------------------------------
  // Release points of the first wait/ack, in clk_i cycles after RAS
  // ----------------------------------------------------------------
  localparam logic [1:0] DWR_REL_AT_RAS = 2'h0;
  localparam logic [1:0] DWR_REL_FALL   = 2'h1;
  localparam logic [1:0] DWR_REL_RISE   = 2'h2;
  localparam logic [1:0] DWR_REL_FALL2  = 2'h3;

  typedef enum logic [1:0] {
    DWR_IDLE = 2'b00,
    DWR_ACC  = 2'b01,
    DWR_RFSH = 2'b10
  } dwr_state_e;

  // ----------------------------------------------------------------
  // Timing tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] dwr_rfsh_len(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return 3'h2;
      2'h1:    return 3'h3;
      2'h2:    return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  function automatic logic [2:0] dwr_prech_len(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      2'h2:    return 3'h2;
      default: return 3'h3;
    endcase
  endfunction

  function automatic logic [2:0] dwr_grant_len(input logic [1:0] sel);
    return sel[0] ? 3'h2 : 3'h1;
  endfunction

  function automatic logic [1:0] dwr_rel_len(input logic ack, input logic [1:0] dsel,
                                             input logic dly);
    if (ack) begin
      unique case (dsel)
        2'h0:    return DWR_REL_AT_RAS;
        2'h1:    return DWR_REL_RISE;
        2'h2:    return DWR_REL_FALL;
        default: return DWR_REL_FALL2;
      endcase
    end
    unique case (dsel)
      2'h0:    return DWR_REL_AT_RAS;
      2'h1:    return DWR_REL_FALL;
      2'h2:    return dly ? DWR_REL_FALL : DWR_REL_AT_RAS;
      default: return DWR_REL_RISE;
    endcase
  endfunction

endpackage

// ### rtl/dwr_sync.sv
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes the inputs are asynchronous levels; pulses shorter than one clock may be lost.
 */
module dwr_sync import dwr_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("dwr_sync: W must be at least 1");
  end

  // Reset to all ones: the pins it carries idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      q_o    <= '1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// ### rtl/dwr_tick_cnt.sv
/*
 * Down counter of controller clock edges with a load and a last-edge flag.
 * Assumes tick_i pulses once per controller rising edge.
 */
module dwr_tick_cnt import dwr_pkg::*; #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] len_i,
  input  wire logic         tick_i,
  // Status
  output logic              last_o
);

  logic [W-1:0] cnt_q;

  if (W < 2) begin : g_chk
    $error("dwr_tick_cnt: W must be at least 2");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= len_i;
    end else if (tick_i && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // Last edge of the interval, or already elapsed
  assign last_o = (cnt_q <= W'(1));

endmodule

// ### rtl/dwr_top.sv
/*
 * Wait/transfer-ack generation and RAS timing of a DRAM controller, with a
 * classic Wishbone slave for configuration and status.
 * Assumes the memory-side pins are asynchronous, and the controller clock is
 * clk_i divided by two (driven out on ctl_clk_o), so each half period is one clk_i.
 */
// Our own choices: the placing of the registers and the Wishbone register port.

// Function
// - Burst field 00, wait style: wait stays negated through the burst.
// - Burst field 00, ack style: ack stays asserted through the burst.
// - Burst 01/10, wait style: wait asserts on negated CAS-extend with request.
// - Burst 01/10, ack style: ack negates on negated CAS-extend with request.
// - Burst 01, wait style: wait negates at next rising edge after CAS-extend.
// - Burst 01, ack style: ack reasserts at next rising edge after CAS-extend.
// - Burst 10, wait style: wait negates in next low phase after CAS-extend.
// - Burst 10, ack style: ack reasserts in next low phase after CAS-extend.
// - Burst 11, wait style: wait simply follows negated CAS-extend.
// - Burst 11, ack style: ack simply follows asserted CAS-extend.
// - Delay 00/10, wait style: no wait for accesses that start undelayed.
// - Delay 00, wait style: delayed access releases wait with the RAS edge.
// - Delay 00, ack style: ack asserts together with access RAS.
// - Delay 01, wait style: wait released in low phase after RAS.
// - Delay 01, ack style: ack asserts on first rising edge after RAS.
// - Delay 10, wait style: delayed access releases wait in low phase after RAS.
// - Delay 10, ack style: ack asserts in low phase after RAS.
// - Delay 11, wait style: wait released on rising edge after RAS.
// - Delay 11, ack style: ack asserts in low phase after next rising edge.
// - Refresh RAS low for 2, 3, 2, 4 rising edges per RAS field.
// - RAS precharge of 1, 2, 2, 3 rising edges per RAS field.
// - After port-B grant change, RAS starts on edge 1 or 2 per field.
// - Style bit: 0 gives wait output, 1 gives transfer-ack output.
module dwr_top import dwr_pkg::*; #(
  parameter int CAS_EXTEND_IN_W    = 4,
  parameter bit DUAL_PORT = 1'b1
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Access side
  input  wire logic              access_request_in_n_i,
  input  wire logic [CAS_EXTEND_IN_W-1:0] cas_extend_in_n_i,
  input  wire logic              port_b_grant_i,
  input  wire logic              refresh_req_i,
  // Strobes and handshake
  output logic                   ras_n_o,
  output logic                   wait_n_o,
  output logic                   transfer_ack_out_n_o,
  output logic                   ctl_clk_o
);

  if (CAS_EXTEND_IN_W < 1 || CAS_EXTEND_IN_W > 8) begin : g_chk
    $error("dwr_top: CAS_EXTEND_IN_W must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [CAS_EXTEND_IN_W+1:0] pin_s;
  logic              req_s;
  logic              cas_s;
  logic              grant_s;

  dwr_sync #(.W(CAS_EXTEND_IN_W + 2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({~port_b_grant_i, access_request_in_n_i, cas_extend_in_n_i}),
    .q_o   (pin_s)
  );

  // Grant enters inverted so every synchronised pin idles high: no false change after reset
  assign grant_s = ~pin_s[CAS_EXTEND_IN_W+1] & DUAL_PORT;
  assign req_s   = ~pin_s[CAS_EXTEND_IN_W];
  // Any CAS-extend asserted counts as asserted
  assign cas_s   = |(~pin_s[CAS_EXTEND_IN_W-1:0]);

  // ----------------------------------------------------------------
  // Wishbone slave and configuration
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic       style;
  logic [1:0] bw_sel;
  logic [1:0] dly_sel;
  logic [1:0] ras_sel;
  logic       wb_req;
  logic       cfg_wr;

  assign style   = cfg_q[DWR_ACK_STYLE_BIT];
  assign bw_sel  = cfg_q[DWR_BW_LSB +: 2];
  assign dly_sel = cfg_q[DWR_DLY_LSB +: 2];
  assign ras_sel = cfg_q[DWR_RAS_LSB +: 2];
  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cfg_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                   & (wb_adr_i == DWR_CFG_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Write lands on the edge the master samples ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= DWR_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Controller clock phase
  // ----------------------------------------------------------------
  logic phase_q;
  logic rise;

  // Rise marks the clk_i edge on which the controller clock goes high
  assign rise      = ~phase_q;
  assign ctl_clk_o = phase_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  // ----------------------------------------------------------------
  // RAS sequencing
  // ----------------------------------------------------------------
  dwr_state_e state_q;
  dwr_state_e state_d;
  logic       tmr_load;
  logic [2:0] tmr_len;
  logic       tmr_last;
  logic       gnt_last;
  logic       grant_prev_q;
  logic       grant_chg;
  logic       may_start;
  logic       start;
  logic       rf_pend_q;
  logic       seen_q;
  logic       delayed_q;
  logic [2:0] gnt_len;
  logic       gnt_now;

  dwr_tick_cnt #(.W(3)) u_ras_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (tmr_load),
    .len_i  (tmr_len),
    .tick_i (rise),
    .last_o (tmr_last)
  );

  assign grant_chg = DUAL_PORT && (grant_s != grant_prev_q);

  dwr_tick_cnt #(.W(3)) u_gnt_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (grant_chg),
    .len_i  (gnt_len),
    .tick_i (rise),
    .last_o (gnt_last)
  );

  // The edge that first sees the grant change counts as the first rise if it is one
  assign gnt_len = dwr_grant_len(ras_sel) - {2'b00, rise};
  assign gnt_now = rise && (dwr_grant_len(ras_sel) == 3'h1);

  // Port A may start only once the grant has settled back
  assign may_start = tmr_last && !grant_s && (grant_chg ? gnt_now : gnt_last);

  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_len  = dwr_prech_len(ras_sel);
    start    = 1'b0;
    if (rise) begin
      unique case (state_q)
        DWR_IDLE: begin
          if (rf_pend_q && tmr_last) begin
            state_d  = DWR_RFSH;
            tmr_load = 1'b1;
            tmr_len  = dwr_rfsh_len(ras_sel);
          end else if (req_s && may_start) begin
            state_d = DWR_ACC;
            start   = 1'b1;
          end
        end
        DWR_ACC: begin
          if (!req_s) begin
            state_d  = DWR_IDLE;
            tmr_load = 1'b1;
          end
        end
        DWR_RFSH: begin
          if (tmr_last) begin
            state_d  = DWR_IDLE;
            tmr_load = 1'b1;
          end
        end
        default: begin
          state_d = DWR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q      <= DWR_IDLE;
      grant_prev_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      grant_prev_q <= grant_s;
    end
  end

  // A request arriving on the refresh's own clear edge is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rf_pend_q <= 1'b0;
    end else if (refresh_req_i) begin
      rf_pend_q <= 1'b1;
    end else if (state_q != DWR_RFSH && state_d == DWR_RFSH) begin
      rf_pend_q <= 1'b0;
    end
  end

  // Delayed access: a rising edge passed while the request waited
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_q    <= 1'b0;
      delayed_q <= 1'b0;
    end else begin
      if (start) begin
        delayed_q <= seen_q;
      end
      if (start || !req_s || state_q == DWR_ACC) begin
        seen_q <= 1'b0;
      end else if (rise) begin
        seen_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wait and transfer-ack generation
  // ----------------------------------------------------------------
  logic [1:0] rel_q;
  logic [1:0] rel_d;
  logic       fdone_q;
  logic       fdone_d;
  logic       hold_q;
  logic       hold_d;
  logic       acc_d;
  logic       busy_d;

  assign acc_d = (state_d == DWR_ACC);

  // First-access release, counted in half periods from the RAS edge
  always_comb begin
    rel_d   = rel_q;
    fdone_d = fdone_q;
    if (start) begin
      rel_d   = dwr_rel_len(style, dly_sel, seen_q);
      fdone_d = (rel_d == DWR_REL_AT_RAS);
    end else if (state_q == DWR_ACC && !fdone_q) begin
      rel_d   = rel_q - 2'h1;
      fdone_d = (rel_q == 2'h1);
    end
    if (!acc_d) begin
      fdone_d = 1'b0;
    end
  end

  // Burst portion: hold back on negated CAS-extend, release per field
  always_comb begin
    hold_d = hold_q;
    if (!acc_d || !fdone_q || bw_sel == 2'h0) begin
      hold_d = 1'b0;
    end else if (bw_sel == 2'h3) begin
      hold_d = !cas_s;
    end else if (!cas_s && req_s) begin
      hold_d = 1'b1;
    end else if (cas_s && hold_q) begin
      if (bw_sel == 2'h1 && rise) begin
        hold_d = 1'b0;
      end else if (bw_sel == 2'h2 && !rise) begin
        hold_d = 1'b0;
      end
    end
  end

  // Before RAS, wait only where every access waits or once delayed
  assign busy_d = acc_d ? (!fdone_d || hold_d)
                        : (req_s && (dly_sel[0] || seen_q || rise));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_q                <= 2'h0;
      fdone_q              <= 1'b0;
      hold_q               <= 1'b0;
      ras_n_o              <= 1'b1;
      wait_n_o             <= 1'b1;
      transfer_ack_out_n_o <= 1'b1;
    end else begin
      rel_q                <= rel_d;
      fdone_q              <= fdone_d;
      hold_q               <= hold_d;
      ras_n_o              <= !(state_d == DWR_ACC || state_d == DWR_RFSH);
      wait_n_o             <= style || !busy_d;
      transfer_ack_out_n_o <= !(style && acc_d && fdone_d && !hold_d);
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      unique case (wb_adr_i)
        DWR_CFG_OFS:  wb_dat_o <= {24'h00_0000, cfg_q};
        DWR_STAT_OFS: wb_dat_o <= {23'h00_0000, rf_pend_q, state_q, fdone_q, hold_q,
                                   delayed_q, grant_s, req_s, cas_s};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_burst_none_wait: assert property (
    (state_q == DWR_ACC && fdone_q && bw_sel == 2'h0 && !style) |-> wait_n_o)
    else $error("wait asserted in burst with no wait states");

  chk_burst_none_ack: assert property (
    (state_q == DWR_ACC && fdone_q && bw_sel == 2'h0 && style) |-> !transfer_ack_out_n_o)
    else $error("ack dropped in burst with no wait states");

  chk_burst_hold_on: assert property (
    (state_q == DWR_ACC && fdone_q && bw_sel != 2'h0 && !cas_s && req_s)
    |=> (style ? transfer_ack_out_n_o : !wait_n_o))
    else $error("burst hold not applied");

  chk_burst_rel_rise: assert property (
    (state_q == DWR_ACC && hold_q && bw_sel == 2'h1 && cas_s && req_s && rise)
    |=> (style ? !transfer_ack_out_n_o : wait_n_o))
    else $error("burst release missed on rising edge");

  chk_burst_rel_fall: assert property (
    (state_q == DWR_ACC && hold_q && bw_sel == 2'h2 && cas_s && req_s && !rise)
    |=> (style ? !transfer_ack_out_n_o : wait_n_o))
    else $error("burst release missed in low phase");

  chk_burst_follow: assert property (
    (state_q == DWR_ACC && fdone_q && bw_sel == 2'h3 && cas_s && req_s)
    |=> (style ? !transfer_ack_out_n_o : wait_n_o))
    else $error("burst output not following CAS-extend");

  chk_ack_with_ras: assert property (
    ($fell(ras_n_o) && state_q == DWR_ACC && style && dly_sel == 2'h0)
    |-> !transfer_ack_out_n_o)
    else $error("ack not with RAS");

  chk_ack_one_edge: assert property (
    ($fell(ras_n_o) && state_q == DWR_ACC && style && dly_sel == 2'h1)
    |-> transfer_ack_out_n_o ##1 transfer_ack_out_n_o ##1 (!transfer_ack_out_n_o || ras_n_o))
    else $error("ack not on first rising edge after RAS");

  chk_wait_one_edge: assert property (
    ($fell(ras_n_o) && state_q == DWR_ACC && !style && dly_sel == 2'h3)
    |-> !wait_n_o ##1 !wait_n_o ##1 (wait_n_o || ras_n_o))
    else $error("wait not released on rising edge after RAS");

  chk_rfsh_width: assert property (
    ($rose(state_q == DWR_RFSH) && ras_sel == 2'h0) |-> !ras_n_o [*4] ##1 ras_n_o)
    else $error("refresh RAS width wrong");

  chk_prech_width: assert property (
    ($rose(ras_n_o) && ras_sel == 2'h3 && $stable(cfg_q)) |-> ras_n_o [*6])
    else $error("RAS precharge too short");

  chk_cfg_hold: assert property (
    !cfg_wr |=> $stable(cfg_q))
    else $error("timing fields changed without programming");

  cov_refresh: cover property ($rose(state_q == DWR_RFSH));
  cov_burst_hold: cover property ($rose(hold_q) ##[1:20] $fell(hold_q));
  cov_delayed: cover property (start && seen_q);

endmodule

// ### verif/dwr_cpu_model.sv
/*
 * CPU-side model: drives the access request and CAS-extend pins.
 * Assumes go_i and gap_i come from the clk_i domain of the bench.
 */
module dwr_cpu_model (
  // Clock
  input  wire logic       clk_i,
  // Bench control
  input  wire logic       go_i,
  input  wire logic       gap_i,
  // Pins
  output logic            req_n_o,
  output logic [3:0]      cas_extend_in_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lane_q = 2'h0;
  initial begin
    req_n_o = 1'b1;
    cas_extend_in_n_o = 4'hf;
  end
  // Asserted lane moves each cycle so no single bit is relied on
  always @(posedge clk_i) begin
    lane_q <= lane_q + 2'h1;
    req_n_o <= ~go_i;
    cas_extend_in_n_o <= (gap_i || !go_i) ? 4'hf : ~(4'h1 << lane_q);
  end
endmodule

// ### verif/dwr_top_tb_top.sv
/*
 * Self-checking bench of dwr_top: Wishbone config, refresh, access timing.
 * Assumes dwr_pkg and dwr_cpu_model are compiled first.
 */
module dwr_top_tb_top import dwr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        go = 1'b0;
  logic        gap = 1'b0;
  logic        grant = 1'b0;
  logic        rfsh = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        req_n;
  logic [3:0]  cas_extend_in_n;
  logic        ras_n;
  logic        wait_n;
  logic        tack_n;
  logic        ctl;
  int          failures = 0;
  int          checks = 0;
  int          seed = 32'h2eae3ac0;

  dwr_top u_dwr_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .access_request_in_n_i(req_n), .cas_extend_in_n_i(cas_extend_in_n),
    .port_b_grant_i(grant), .refresh_req_i(rfsh), .ras_n_o(ras_n),
    .wait_n_o(wait_n), .transfer_ack_out_n_o(tack_n), .ctl_clk_o(ctl)
  );
  dwr_cpu_model u_dwr_cpu_model (
    .clk_i(clk_i), .go_i(go), .gap_i(gap), .req_n_o(req_n), .cas_extend_in_n_o(cas_extend_in_n)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // Negedges until cond holds, bounded
  task automatic cnt_until(input int sel, output int n);
    n = 0;
    while (n < 100 && !(sel == 0 ? tack_n === 1'b0 : sel == 1 ? wait_n === 1'b1 :
           sel == 2 ? ras_n === 1'b0 : ras_n === 1'b1)) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 100) failures++;
  endtask

  function automatic int first_rel(input logic ackst, input logic [1:0] d);
    return ackst ? (d == 2'h1 ? 2 : d == 2'h2 ? 1 : d == 2'h3 ? 3 : 0)
                 : (d == 2'h1 ? 1 : d == 2'h3 ? 2 : 0);
  endfunction

  function automatic int rfsh_clk(input logic [1:0] r);
    return r == 2'h1 ? 6 : r == 2'h3 ? 8 : 4;
  endfunction

  function automatic int prech_clk(input logic [1:0] r);
    return r == 2'h0 ? 2 : r == 2'h3 ? 6 : 4;
  endfunction

  // ----------------------------------------------------------------
  // Access: first release, burst hold and release
  // ----------------------------------------------------------------
  task automatic access(input logic [7:0] cfg);
    logic [31:0] q;
    int   n;
    logic held;
    wb(1'b1, DWR_CFG_OFS, {24'h0, cfg}, q);
    go <= 1'b1;
    cnt_until(2, n);
    cnt_until(cfg[7] ? 0 : 1, n);
    if (cfg[7]) check(n, first_rel(1'b1, cfg[3:2]));
    else check(n, first_rel(1'b0, cfg[3:2]));
    check(cfg[7] ? wait_n : tack_n, 1'b1);
    @(posedge clk_i);
    gap <= 1'b1;
    held = 1'b0;
    repeat (8) begin
      @(negedge clk_i);
      if (cfg[7] ? tack_n === 1'b1 : wait_n === 1'b0) held = 1'b1;
    end
    check(held, cfg[5:4] != 2'h0);
    @(posedge clk_i);
    gap <= 1'b0;
    cnt_until(cfg[7] ? 0 : 1, n);
    check(n <= (cfg[5:4] == 2'h3 ? 5 : 7), 1'b1);
    @(posedge clk_i);
    go <= 1'b0;
    cnt_until(3, n);
    repeat (20) @(posedge clk_i);
    $display("access cfg=%h done", cfg);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [7:0]  c;
    int          n;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({ras_n, wait_n, tack_n}, 3'h7);
    c = {7'h0, ctl};
    @(posedge clk_i);
    check(ctl, !c[0]);
    wb(1'b0, DWR_CFG_OFS, 32'h0, q);
    check(q, {24'h0, DWR_CFG_RST});
    wb(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    repeat (6) begin
      c = 8'($random(seed));
      wb(1'b1, DWR_CFG_OFS, {$random(seed)} & 32'hffffff00 | c, q);
      wb(1'b0, DWR_CFG_OFS, 32'h0, q);
      check(q, {24'h0, c});
    end
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      access({i[0], 1'b0, 2'($random(seed)), i[2:1], 2'h0});
    end
    for (int b = 0; b < 4; b++) begin
      access({1'b1, 1'b0, b[1:0], 2'h1, 2'h0});
    end
    for (int r = 0; r < 4; r++) begin
      // Fields 10 and 11 also give the waiting access delay setting 10
      wb(1'b1, DWR_CFG_OFS, {28'h0, r[1], 1'b0, r[1:0]}, q);
      rfsh <= 1'b1;
      @(posedge clk_i);
      rfsh <= 1'b0;
      go <= 1'b1;
      cnt_until(2, n);
      cnt_until(3, n);
      check(n, rfsh_clk(r[1:0]));
      check(wait_n, 1'b0);
      cnt_until(2, n);
      check(n, prech_clk(r[1:0]));
      check(wait_n, !r[1]);
      @(negedge clk_i);
      check(wait_n, 1'b1);
      @(posedge clk_i);
      go <= 1'b0;
      cnt_until(3, n);
      repeat (20) @(posedge clk_i);
      grant <= 1'b1;
      go <= 1'b1;
      repeat (20) @(posedge clk_i);
      check(ras_n, 1'b1);
      wb(1'b0, DWR_STAT_OFS, 32'h0, q);
      check(q, 32'h0000_000f);
      grant <= 1'b0;
      cnt_until(2, n);
      check(n >= (r[0] ? 6 : 4) && n <= (r[0] ? 7 : 5), 1'b1);
      @(posedge clk_i);
      go <= 1'b0;
      cnt_until(3, n);
      repeat (20) @(posedge clk_i);
      $display("refresh field %0d done", r);
    end
    end_sim();
  end

  initial begin
    #160000;
    failures++;
    end_sim();
  end
endmodule
